// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench;
   import tpc_pkg::*;
   logic              clk_sys_i, arst_n_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
   logic [ADDR_W-1:0] awaddr_i, araddr_i;
   logic [31:0]       wdata_i, rdata_o, history_data_i, final_sum_i, rd;
   logic [3:0]        wstrb_i, fp_input_en_o, coinc_window_o;
   logic [1:0]        bresp_o, rresp_o, rsp;
   logic              awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
   logic [5:0]        chan_up_i, payload_enable_o;
   logic [11:0]       lane_up_i;
   logic              fiber_ready_i, fiber_remote_up_i, fiber_byte_align_i, fiber_chan_align_i;
   logic              sum_error_i, alignment_complete_i, history_ready_i;
   logic [15:0]       die_temp_i, core_volt_i, crate_id_o, cal_threshold_o;
   logic              sync_i, first_trigger_i, second_trigger_i, dist_clk_div4_i;
   logic              history_arm_o, init_trx_o, fiber_reset_o, align_enable_o, align_strobe_o;
   logic              history_advance_o, trigger_out_o, coarse_map_sel_o;
   logic [6:0]        cal_window_o;
   int                errors = 0, samples_checked = 0, adv_cnt = 0, strobe_cnt = 0;

   tpc_regs dut (.clk_sys_i, .arst_n_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i,
      .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o,
      .rdata_o, .rresp_o, .rvalid_o, .rready_i, .chan_up_i, .lane_up_i, .fiber_ready_i,
      .fiber_remote_up_i, .fiber_byte_align_i, .fiber_chan_align_i, .sum_error_i,
      .alignment_complete_i, .history_ready_i, .history_data_i, .die_temp_i, .core_volt_i,
      .final_sum_i, .sync_i, .first_trigger_i, .second_trigger_i, .dist_clk_div4_i,
      .payload_enable_o, .history_arm_o, .init_trx_o, .fiber_reset_o, .align_enable_o,
      .align_strobe_o, .history_advance_o, .trigger_out_o, .crate_id_o, .fp_input_en_o,
      .coarse_map_sel_o, .coinc_window_o, .cal_window_o, .cal_threshold_o);

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // Fastest pattern a synchronous input can carry
   always @(posedge clk_sys_i) dist_clk_div4_i <= arst_n_i ? ~dist_clk_div4_i : 1'b0;

   always @(negedge clk_sys_i) begin
      if (history_advance_o === 1'b1) adv_cnt++;
      if (align_strobe_o === 1'b1) strobe_cnt++;
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_near(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if ($isunknown(got) || got > exp + 32'h2 || got + 32'h2 < exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axi_write(input logic [5:0] idx, input logic [15:0] d, output logic [1:0] r);
      logic aw_now, w_now, done;
      done = 1'b0;
      @(posedge clk_sys_i);
      awaddr_i  <= {idx, 2'b00};
      wdata_i   <= {16'h0000, d};
      awvalid_i <= 1'b1;
      wvalid_i  <= 1'b1;
      bready_i  <= 1'b1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(negedge clk_sys_i);
         aw_now = awvalid_i & awready_o;
         w_now  = wvalid_i & wready_o;
         done   = (bvalid_o === 1'b1);
         r      = bresp_o;
         @(posedge clk_sys_i);
         if (aw_now) awvalid_i <= 1'b0;
         if (w_now) wvalid_i <= 1'b0;
         if (done) bready_i <= 1'b0;
      end
      if (!done) begin
         check(32'h0, 32'h1);
         finish_test();
      end
   endtask

   task automatic axi_read(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
      logic ar_now, done;
      done = 1'b0;
      @(posedge clk_sys_i);
      araddr_i  <= {idx, 2'b00};
      arvalid_i <= 1'b1;
      rready_i  <= 1'b1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(negedge clk_sys_i);
         ar_now = arvalid_i & arready_o;
         done   = (rvalid_o === 1'b1);
         d      = rdata_o;
         r      = rresp_o;
         @(posedge clk_sys_i);
         if (ar_now) arvalid_i <= 1'b0;
         if (done) rready_i <= 1'b0;
      end
      if (!done) begin
         check(32'h0, 32'h1);
         finish_test();
      end
   endtask

   task automatic wr(input logic [5:0] idx, input logic [15:0] d);
      axi_write(idx, d, rsp);
      check(rsp, RESP_OKAY);
      @(negedge clk_sys_i);
   endtask

   task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
      axi_read(idx, rd, rsp);
      check(rsp, RESP_OKAY);
      check(rd, exp);
   endtask

   // Held three cycles, the minimum pulse the board may send
   task automatic pulse(input logic [2:0] sel);
      @(posedge clk_sys_i);
      {sync_i, first_trigger_i, second_trigger_i} <= sel;
      repeat (3) @(posedge clk_sys_i);
      {sync_i, first_trigger_i, second_trigger_i} <= 3'b000;
      repeat (3) @(posedge clk_sys_i);
   endtask

   initial begin
      logic [5:0]  cu;
      logic [11:0] lu;
      logic [6:0]  fl;
      logic [15:0] wv [5];
      logic [5:0]  rw_idx [5];
      int          base;
      rw_idx = '{IDX_THR_LO, IDX_THR_HI, IDX_CRATE, IDX_CFG3, IDX_CFG4};
      arst_n_i = 1'b0;
      {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 5'h00;
      awaddr_i = '0;
      araddr_i = '0;
      wdata_i = 32'h0;
      wstrb_i = 4'hf;
      {chan_up_i, lane_up_i} = 18'h0;
      {fiber_ready_i, fiber_remote_up_i, fiber_byte_align_i, fiber_chan_align_i} = 4'h0;
      {sum_error_i, alignment_complete_i, history_ready_i} = 3'h0;
      {history_data_i, final_sum_i} = 64'h0;
      {die_temp_i, core_volt_i} = 32'h0;
      {sync_i, first_trigger_i, second_trigger_i} = 3'h0;
      repeat (2) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      @(negedge clk_sys_i);
      check({awready_o, wready_o, arready_o, bvalid_o, rvalid_o}, 5'b11100);
      for (int k = 0; k <= 12; k++) begin
         @(posedge clk_sys_i);
         cu = (k == 12) ? 6'h3f : 6'h01 << (k % 6);
         lu = 12'h001 << k;
         fl = 7'(k * 37);
         chan_up_i <= cu;
         lane_up_i <= lu;
         {alignment_complete_i, sum_error_i, fiber_ready_i, fiber_remote_up_i,
            fiber_byte_align_i, fiber_chan_align_i, history_ready_i} <= fl;
         rdchk(IDX_STAT0, {16'h0, cu[1], cu[4], cu[0], cu[2], lu[11:10], lu[7:6], lu[3:2],
            lu[9:8], lu[1:0], lu[5:4]});
         rdchk(IDX_STAT1, {22'h0, fl, cu[5], &cu, cu[3]});
      end
      die_temp_i <= 16'h1234;
      core_volt_i <= 16'hbeef;
      history_data_i <= 32'hcafe_5a5a;
      rdchk(IDX_TEMP, 32'h1234);
      rdchk(IDX_VINT, 32'hbeef);
      rdchk(IDX_VERSION, {17'h0, FW_VERSION});
      base = adv_cnt;
      rdchk(IDX_HIST_LO, 32'h5a5a);
      repeat (3) @(posedge clk_sys_i);
      check(32'(adv_cnt - base), 32'h0);
      rdchk(IDX_HIST_HI, 32'hcafe);
      repeat (3) @(posedge clk_sys_i);
      check(32'(adv_cnt - base), 32'h1);
      wr(IDX_HIST_HI, 16'h0000);
      rdchk(IDX_HIST_HI, 32'hcafe);
      for (int k = 0; k < 5; k++) begin
         wv[k] = 16'hb5a3 + 16'(k * 16'h1021);
         wr(rw_idx[k], wv[k]);
      end
      for (int k = 0; k < 5; k++) rdchk(rw_idx[k], {16'h0, wv[k]});
      check(crate_id_o, wv[2]);
      check(cal_threshold_o, wv[4]);
      check({fp_input_en_o, coarse_map_sel_o, coinc_window_o, cal_window_o}, wv[3]);
      wr(IDX_CFG3, 16'h4c5d);
      check({fp_input_en_o, coarse_map_sel_o, coinc_window_o, cal_window_o}, 16'h4c5d);
      @(posedge clk_sys_i);
      final_sum_i <= {wv[1], wv[0]};
      repeat (3) @(negedge clk_sys_i);
      check(trigger_out_o, 1'b0);
      @(posedge clk_sys_i);
      final_sum_i <= {wv[1], wv[0]} + 32'h1;
      repeat (3) @(negedge clk_sys_i);
      check(trigger_out_o, 1'b1);
      // Low byte strobe only: high byte keeps its old value
      @(posedge clk_sys_i);
      wstrb_i <= 4'h1;
      wr(IDX_THR_HI, 16'h0000);
      @(posedge clk_sys_i);
      wstrb_i <= 4'hf;
      rdchk(IDX_THR_HI, {16'h0, wv[1][15:8], 8'h00});
      wr(IDX_CFG0, 16'h002a);
      check(payload_enable_o, 6'h2a);
      rdchk(IDX_CFG0, 32'h2a);
      wr(IDX_CFG1, 16'h0007);
      check({align_enable_o, fiber_reset_o, init_trx_o, history_arm_o}, 4'h7);
      base = strobe_cnt;
      pulse(3'b100);
      check(32'(strobe_cnt - base), 32'h0);
      wr(IDX_CFG1, 16'h0008);
      check({align_enable_o, fiber_reset_o, init_trx_o, history_arm_o}, 4'h8);
      pulse(3'b100);
      check(32'(strobe_cnt - base), 32'h1);
      wr(IDX_CLR, 16'h0007);
      pulse(3'b111);
      pulse(3'b110);
      pulse(3'b100);
      rdchk(IDX_CNT_SYNC, 32'h3);
      rdchk(IDX_CNT_T1, 32'h2);
      rdchk(IDX_CNT_T2, 32'h1);
      wr(IDX_CNT_SYNC, 16'hffff);
      rdchk(IDX_CNT_SYNC, 32'h3);
      wr(IDX_CLR, 16'h0005);
      rdchk(IDX_CLR, 32'h5);
      rdchk(IDX_CNT_SYNC, 32'h0);
      rdchk(IDX_CNT_T1, 32'h2);
      rdchk(IDX_CNT_T2, 32'h0);
      pulse(3'b111);
      rdchk(IDX_CNT_SYNC, 32'h1);
      rdchk(IDX_CNT_T1, 32'h3);
      axi_read(6'h06, rd, rsp);
      check(rsp, RESP_SLVERR);
      check(rd, 32'h0);
      axi_write(6'h15, 16'h0001, rsp);
      check(rsp, RESP_SLVERR);
      // Divided board clock toggling every cycle gives 200 rising edges per gate
      repeat (800) @(posedge clk_sys_i);
      axi_read(IDX_FREQ, rd, rsp);
      check_near(rd, 32'd200);
      finish_test();
   end
endmodule // testbench

// ==== tpc_pkg.sv ====
package tpc_pkg;
   localparam int          ADDR_W        = 8;
   // Register indices; byte address is four times the index
   localparam logic [5:0]  IDX_STAT0     = 6'h00;
   localparam logic [5:0]  IDX_STAT1     = 6'h01;
   localparam logic [5:0]  IDX_CFG0      = 6'h02;
   localparam logic [5:0]  IDX_CFG1      = 6'h03;
   localparam logic [5:0]  IDX_TEMP      = 6'h04;
   localparam logic [5:0]  IDX_VINT      = 6'h05;
   localparam logic [5:0]  IDX_THR_LO    = 6'h08;
   localparam logic [5:0]  IDX_THR_HI    = 6'h09;
   localparam logic [5:0]  IDX_HIST_LO   = 6'h0a;
   localparam logic [5:0]  IDX_HIST_HI   = 6'h0b;
   localparam logic [5:0]  IDX_CLR       = 6'h0c;
   localparam logic [5:0]  IDX_FREQ      = 6'h0d;
   localparam logic [5:0]  IDX_CNT_SYNC  = 6'h0e;
   localparam logic [5:0]  IDX_CNT_T1    = 6'h0f;
   localparam logic [5:0]  IDX_CNT_T2    = 6'h10;
   localparam logic [5:0]  IDX_VERSION   = 6'h11;
   localparam logic [5:0]  IDX_CRATE     = 6'h12;
   localparam logic [5:0]  IDX_CFG3      = 6'h13;
   localparam logic [5:0]  IDX_CFG4      = 6'h14;
   // Config word 1 field positions
   localparam int          CFG1_HIST_ARM = 0;
   localparam int          CFG1_INIT_TRX = 1;
   localparam int          CFG1_FIB_RST  = 2;
   localparam int          CFG1_ALIGN_EN = 3;
   localparam logic [15:0] REG_RESET_VAL = 16'h0000;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   localparam logic [14:0] FW_VERSION    = 15'h0001; // Arbitrary value
   // Frequency gate: board clock arrives divided by four
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          FREQ_GATE_NS  = 4000;
   localparam int          FREQ_GATE_CYC = FREQ_GATE_NS / CLK_PERIOD_NS;
endpackage

// ==== tpc_regs.sv ====
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module tpc_regs
   import tpc_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire logic              arst_n_i,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] awaddr_i,
   input  wire logic              awvalid_i,
   output      logic              awready_o,
   input  wire logic [31:0]       wdata_i,
   input  wire logic [3:0]        wstrb_i,
   input  wire logic              wvalid_i,
   output      logic              wready_o,
   output      logic [1:0]        bresp_o,
   output      logic              bvalid_o,
   input  wire logic              bready_i,
   input  wire logic [ADDR_W-1:0] araddr_i,
   input  wire logic              arvalid_i,
   output      logic              arready_o,
   output      logic [31:0]       rdata_o,
   output      logic [1:0]        rresp_o,
   output      logic              rvalid_o,
   input  wire logic              rready_i,
   // Status sources, bit n is payload n+1
   input  wire logic [5:0]        chan_up_i,
   input  wire logic [11:0]       lane_up_i,
   input  wire logic              fiber_ready_i,
   input  wire logic              fiber_remote_up_i,
   input  wire logic              fiber_byte_align_i,
   input  wire logic              fiber_chan_align_i,
   input  wire logic              sum_error_i,
   input  wire logic              alignment_complete_i,
   input  wire logic              history_ready_i,
   input  wire logic [31:0]       history_data_i,
   input  wire logic [15:0]       die_temp_i,
   input  wire logic [15:0]       core_volt_i,
   input  wire logic [31:0]       final_sum_i,
   // Signal distribution board inputs
   input  wire logic              sync_i,
   input  wire logic              first_trigger_i,
   input  wire logic              second_trigger_i,
   input  wire logic              dist_clk_div4_i,
   // Control outputs
   output      logic [5:0]        payload_enable_o,
   output      logic              history_arm_o,
   output      logic              init_trx_o,
   output      logic              fiber_reset_o,
   output      logic              align_enable_o,
   output      logic              align_strobe_o,
   output      logic              history_advance_o,
   output      logic              trigger_out_o,
   output      logic [15:0]       crate_id_o,
   output      logic [3:0]        fp_input_en_o,
   output      logic              coarse_map_sel_o,
   output      logic [3:0]        coinc_window_o,
   output      logic [6:0]        cal_window_o,
   output      logic [15:0]       cal_threshold_o
);

   typedef struct packed {
      logic             awready;
      logic             wready;
      logic             aw_full;
      logic [5:0]       aw_idx;
      logic             w_full;
      logic [15:0]      wdata;
      logic [1:0]       wstrb;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             arready;
      logic             rvalid;
      logic [1:0]       rresp;
      logic [31:0]      rdata;
      logic [5:0]       cfg0;
      logic [3:0]       cfg1;
      logic [15:0]      thr_lo;
      logic [15:0]      thr_hi;
      logic [2:0]       clr_ctl;
      logic [15:0]      crate;
      logic [15:0]      cfg3;
      logic [15:0]      cfg4;
      logic [2:0]       edge_prev;
      logic [2:0][15:0] cnt;
      logic             dclk_prev;
      logic [8:0]       gate_cnt;
      logic [8:0]       dclk_edges;
      logic [7:0]       freq;
      logic             trig_out;
      logic             align_stb;
      logic             hist_adv;
   } tpc_state_t;

   tpc_state_t s_reg;
   tpc_state_t s_next;

   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  strb);
      logic [15:0] r;
      r = old_v;
      if (strb[0]) begin
         r[7:0] = new_v[7:0];
      end
      if (strb[1]) begin
         r[15:8] = new_v[15:8];
      end
      return r;
   endfunction

   always_comb begin
      logic [15:0] rd;
      logic        rd_err;
      logic [2:0]  clr;
      logic [2:0]  ev;
      logic [5:0]  ridx;
      logic [15:0] mrg;
      mrg    = 16'h0000;
      rd     = 16'h0000;
      rd_err = 1'b0;
      clr    = 3'h0;
      ev     = {second_trigger_i, first_trigger_i, sync_i};
      ridx   = araddr_i[7:2];
      s_next = s_reg;
      s_next.hist_adv  = 1'b0;
      s_next.align_stb = 1'b0;

      // Write address and data taken independently
      if (s_reg.awready && awvalid_i) begin
         s_next.aw_full = 1'b1;
         s_next.aw_idx  = awaddr_i[7:2];
      end
      if (s_reg.wready && wvalid_i) begin
         s_next.w_full = 1'b1;
         s_next.wdata  = wdata_i[15:0];
         s_next.wstrb  = wstrb_i[1:0];
      end
      if (s_reg.bvalid && bready_i) begin
         s_next.bvalid = 1'b0;
      end
      if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid) begin
         s_next.aw_full = 1'b0;
         s_next.w_full  = 1'b0;
         s_next.bvalid  = 1'b1;
         s_next.bresp   = RESP_OKAY;
         case (s_reg.aw_idx)
            IDX_CFG0: begin
               mrg         = merge16({10'h000, s_reg.cfg0}, s_reg.wdata, s_reg.wstrb);
               s_next.cfg0 = mrg[5:0];
            end
            IDX_CFG1: begin
               mrg         = merge16({12'h000, s_reg.cfg1}, s_reg.wdata, s_reg.wstrb);
               s_next.cfg1 = mrg[3:0];
            end
            IDX_THR_LO: s_next.thr_lo = merge16(s_reg.thr_lo, s_reg.wdata, s_reg.wstrb);
            IDX_THR_HI: s_next.thr_hi = merge16(s_reg.thr_hi, s_reg.wdata, s_reg.wstrb);
            IDX_CLR: begin
               mrg            = merge16({13'h0000, s_reg.clr_ctl}, s_reg.wdata, s_reg.wstrb);
               s_next.clr_ctl = mrg[2:0];
               clr            = mrg[2:0];
            end
            IDX_CRATE: s_next.crate = merge16(s_reg.crate, s_reg.wdata, s_reg.wstrb);
            IDX_CFG3:  s_next.cfg3  = merge16(s_reg.cfg3, s_reg.wdata, s_reg.wstrb);
            IDX_CFG4:  s_next.cfg4  = merge16(s_reg.cfg4, s_reg.wdata, s_reg.wstrb);
            IDX_STAT0, IDX_STAT1, IDX_TEMP, IDX_VINT, IDX_HIST_LO, IDX_HIST_HI,
            IDX_FREQ, IDX_CNT_SYNC, IDX_CNT_T1, IDX_CNT_T2, IDX_VERSION: begin
               s_next.bresp = RESP_OKAY;
            end
            default: s_next.bresp = RESP_SLVERR;
         endcase
      end
      s_next.awready = !s_next.aw_full;
      s_next.wready  = !s_next.w_full;

      // Read mux
      case (ridx)
         IDX_STAT0: rd = {chan_up_i[1], chan_up_i[4], chan_up_i[0], chan_up_i[2],
                          lane_up_i[11:10], lane_up_i[7:6], lane_up_i[3:2],
                          lane_up_i[9:8], lane_up_i[1:0], lane_up_i[5:4]};
         IDX_STAT1: rd = {6'h00, alignment_complete_i, sum_error_i,
                          fiber_ready_i, fiber_remote_up_i,
                          fiber_byte_align_i, fiber_chan_align_i,
                          history_ready_i,
                          chan_up_i[5], &chan_up_i, chan_up_i[3]};
         IDX_CFG0:     rd = {10'h000, s_reg.cfg0};
         IDX_CFG1:     rd = {12'h000, s_reg.cfg1};
         IDX_TEMP:     rd = die_temp_i;
         IDX_VINT:     rd = core_volt_i;
         IDX_THR_LO:   rd = s_reg.thr_lo;
         IDX_THR_HI:   rd = s_reg.thr_hi;
         IDX_HIST_LO:  rd = history_data_i[15:0];
         IDX_HIST_HI:  rd = history_data_i[31:16];
         IDX_CLR:      rd = {13'h0000, s_reg.clr_ctl};
         IDX_FREQ:     rd = {8'h00, s_reg.freq};
         IDX_CNT_SYNC: rd = s_reg.cnt[0];
         IDX_CNT_T1:   rd = s_reg.cnt[1];
         IDX_CNT_T2:   rd = s_reg.cnt[2];
         IDX_VERSION:  rd = {1'b0, FW_VERSION};
         IDX_CRATE:    rd = s_reg.crate;
         IDX_CFG3:     rd = s_reg.cfg3;
         IDX_CFG4:     rd = s_reg.cfg4;
         default:      rd_err = 1'b1;
      endcase
      if (s_reg.rvalid && rready_i) begin
         s_next.rvalid = 1'b0;
      end
      if (s_reg.arready && arvalid_i) begin
         s_next.rvalid = 1'b1;
         s_next.rdata  = {16'h0000, rd};
         s_next.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
         if (ridx == IDX_HIST_HI) begin
            s_next.hist_adv = 1'b1;
         end
      end
      s_next.arready = !s_next.rvalid;

      // Edge counters; an edge in the clearing cycle still counts
      for (int i = 0; i < 3; i++) begin
         if (clr[i]) begin
            s_next.cnt[i] = 16'h0000;
         end
         if (ev[i] && !s_reg.edge_prev[i]) begin
            s_next.cnt[i] = (clr[i] ? 16'h0000 : s_reg.cnt[i]) + 16'h0001;
         end
      end
      s_next.edge_prev = ev;

      // Frequency: edges of divided clock over the gate give MHz
      s_next.dclk_prev = dist_clk_div4_i;
      if (s_reg.gate_cnt == 9'(FREQ_GATE_CYC - 1)) begin
         s_next.gate_cnt   = 9'h000;
         s_next.dclk_edges = 9'h000;
         s_next.freq       = s_reg.dclk_edges[8] ? 8'hff : s_reg.dclk_edges[7:0];
      end else begin
         s_next.gate_cnt = s_reg.gate_cnt + 9'h001;
         if (dist_clk_div4_i && !s_reg.dclk_prev && !s_reg.dclk_edges[8]) begin
            s_next.dclk_edges = s_reg.dclk_edges + 9'h001;
         end
      end

      s_next.trig_out  = final_sum_i > {s_reg.thr_hi, s_reg.thr_lo};
      s_next.align_stb = s_reg.cfg1[CFG1_ALIGN_EN] && s_reg.edge_prev[0] && !sync_i;
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_reg         <= '0;
         s_reg.awready <= 1'b1;
         s_reg.wready  <= 1'b1;
         s_reg.arready <= 1'b1;
         s_reg.thr_lo  <= REG_RESET_VAL;
         s_reg.thr_hi  <= REG_RESET_VAL;
         s_reg.crate   <= REG_RESET_VAL;
         s_reg.cfg3    <= REG_RESET_VAL;
         s_reg.cfg4    <= REG_RESET_VAL;
      end else begin
         s_reg <= s_next;
      end
   end

   assign awready_o         = s_reg.awready;
   assign wready_o          = s_reg.wready;
   assign bresp_o           = s_reg.bresp;
   assign bvalid_o          = s_reg.bvalid;
   assign arready_o         = s_reg.arready;
   assign rdata_o           = s_reg.rdata;
   assign rresp_o           = s_reg.rresp;
   assign rvalid_o          = s_reg.rvalid;
   assign payload_enable_o  = s_reg.cfg0;
   assign history_arm_o     = s_reg.cfg1[CFG1_HIST_ARM];
   assign init_trx_o        = s_reg.cfg1[CFG1_INIT_TRX];
   assign fiber_reset_o     = s_reg.cfg1[CFG1_FIB_RST];
   assign align_enable_o    = s_reg.cfg1[CFG1_ALIGN_EN];
   assign align_strobe_o    = s_reg.align_stb;
   assign history_advance_o = s_reg.hist_adv;
   assign trigger_out_o     = s_reg.trig_out;
   assign crate_id_o        = s_reg.crate;
   assign fp_input_en_o     = s_reg.cfg3[15:12];
   assign coarse_map_sel_o  = s_reg.cfg3[11];
   assign coinc_window_o    = s_reg.cfg3[10:7];
   assign cal_window_o      = s_reg.cfg3[6:0];
   assign cal_threshold_o   = s_reg.cfg4;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);

   a_lane_status_read: assert property (
      arvalid_i && arready_o && araddr_i[7:2] == IDX_STAT0
      |=> rvalid_o && rdata_o[15:12] == $past({chan_up_i[1], chan_up_i[4],
                                               chan_up_i[0], chan_up_i[2]}))
      else $error("status word 0 channel bits wrong");

   a_all_up_bit: assert property (
      arvalid_i && arready_o && araddr_i[7:2] == IDX_STAT1
      |=> rdata_o[1] == $past(&chan_up_i) && rdata_o[31:10] == 22'h000000)
      else $error("status word 1 all-up bit wrong");

   a_align_strobe: assert property (
      $fell(sync_i) && align_enable_o |=> align_strobe_o)
      else $error("alignment strobe missing on sync fall");

   a_align_off: assert property (
      align_strobe_o |-> $past(align_enable_o, 1) && !$past(sync_i, 1))
      else $error("alignment strobe while disabled");

   a_thr_write: assert property (
      s_reg.aw_full && s_reg.w_full && !bvalid_o && s_reg.aw_idx == IDX_THR_LO
      && s_reg.wstrb == 2'h3 |=> bvalid_o ##0 s_reg.thr_lo == $past(s_reg.wdata))
      else $error("threshold low half not stored");

   a_hist_advance: assert property (
      arvalid_i && arready_o && araddr_i[7:2] == IDX_HIST_HI |=> history_advance_o
      ##1 !history_advance_o)
      else $error("history advance pulse wrong");

   a_sync_count: assert property (
      $rose(sync_i) && !(bvalid_o == 1'b0 && s_reg.aw_full && s_reg.w_full)
      |=> s_reg.cnt[0] == $past(s_reg.cnt[0]) + 16'h0001)
      else $error("sync edge not counted");

   a_count_clear: assert property (
      s_reg.aw_full && s_reg.w_full && !bvalid_o && s_reg.aw_idx == IDX_CLR
      && s_reg.wstrb[0] && s_reg.wdata[1] && !(first_trigger_i && !s_reg.edge_prev[1])
      |=> s_reg.cnt[1] == 16'h0000)
      else $error("trigger one counter not cleared");

   a_trig_compare: assert property (
      ##1 trigger_out_o == ($past(final_sum_i) > $past({s_reg.thr_hi, s_reg.thr_lo})))
      else $error("trigger output disagrees with compare");

   a_freq_range: assert property (
      s_reg.gate_cnt == 9'(FREQ_GATE_CYC - 1) && !s_reg.dclk_edges[8]
      |=> s_reg.gate_cnt == 9'h000 && s_reg.dclk_edges == 9'h000
      && s_reg.freq == $past(s_reg.dclk_edges[7:0]))
      else $error("frequency gate result wrong");

endmodule // tpc_regs
